// file: common/ahc_pkg.sv
// Purpose: shared constants and types for the converter host-control block
// Assumes: 32-bit classic wishbone, one 100 MHz clock
// Notes: register offsets are byte addresses
package ahc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DATA_W = 16;
  localparam int NUM_PAIRS = 3;
  localparam int NUM_CH = 6;
  localparam int CONV_TICKS = 20;
  localparam logic [2:0] CH_LAST = 3'h5;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_WORD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FRAME_COUNT = 8'h08;
  localparam logic [31:0] CONTROL_WORD_RST = 32'h000003ff;
  localparam int BIT_SEQ_MODE = 23;
  localparam int BIT_CLK_SRC = 11;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_PD = 3;
  localparam int ST_STANDBY = 6;
  localparam int ST_SPAN4 = 7;
  localparam int ST_EXT_CLK = 8;
  localparam int ST_SW_CFG = 9;
  localparam int ST_SERIAL = 10;
  localparam int ST_HALF = 11;
  localparam int ST_CH = 12;
  // ---------------------------------------------------------------
  // synchronised control pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic parallel_select_n;
    logic read_enable_n;
    logic [NUM_PAIRS-1:0] pair_start;
    logic standby_n;
    logic span_clk;
    logic reset_pin;
    logic bus_width_select;
    logic high_byte_first;
    logic config_source_select;
    logic interface_select;
  } ahc_pins_t;
  localparam int PINS_W = $bits(ahc_pins_t);
endpackage : ahc_pkg

// file: verif/ahc_host_model.sv
// Purpose: host processor driving the converter control pins
// Assumes: all pin changes follow a rising clock edge
// Notes: callers other than t_drop hold a start high until busy falls
`timescale 1ns/1ns
`default_nettype none
module ahc_host_model (
  input wire logic clk_i,
  input wire logic [15:0] data_i,
  input wire logic oe_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic [2:0] start_o,
  output logic reset_pin_o
);
  // ----
  // pin tasks
  // ----
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    start_o = 3'h0;
    reset_pin_o = 1'b0;
  end
  task automatic cs(input logic v);
    cs_n_o <= v;
    repeat (4) @(posedge clk_i);
  endtask : cs
  task automatic start(input logic [2:0] m);
    start_o <= m;
    @(posedge clk_i);
  endtask : start
  task automatic pulse(input int n);
    reset_pin_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    reset_pin_o <= 1'b0;
    @(posedge clk_i);
  endtask : pulse
  task automatic rd(output logic [15:0] d, output logic g);
    int n;
    rd_n_o <= 1'b0;
    g = 1'b0;
    d = 16'h0;
    n = 0;
    while (!g && n < 10) begin
      @(posedge clk_i);
      n++;
      if (oe_i === 1'b1) begin
        g = 1'b1;
        d = data_i;
      end
    end
    rd_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask : rd
endmodule : ahc_host_model
`default_nettype wire

// file: verif/ahc_top_sva.sv
// Purpose: port assertions for ahc_top
// Assumes: pins reach the logic through a 2-flop sync
// Notes: bound from the bench top
`timescale 1ns/1ns
`default_nettype none
module ahc_top_sva
  import ahc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic parallel_select_n_i,
  input wire logic read_enable_n_i,
  input wire logic [NUM_PAIRS-1:0] pair_start_i,
  input wire logic standby_n_i,
  input wire logic span_clk_i,
  input wire logic reset_pin_i,
  input wire logic bus_width_select_i,
  input wire logic config_source_select_i,
  input wire logic interface_select_i,
  input wire logic [DATA_W-1:0] data_bus_o,
  input wire logic data_bus_oe_o,
  input wire logic busy_o,
  input wire logic powered_o,
  input wire logic span_4ref_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_cs_idle;
    parallel_select_n_i [*5];
  endsequence
  sequence s_byte_read;
    bus_width_select_i [*6] ##0 data_bus_oe_o;
  endsequence
  AST_CS_GATES_OE: assert property (s_cs_idle |-> !data_bus_oe_o)
    else $error("bus driven while deselected");
  AST_RD_GATES_OE: assert property (read_enable_n_i [*5] |-> !data_bus_oe_o)
    else $error("bus driven without read strobe");
  AST_SERIAL_NO_OE: assert property (interface_select_i [*5] |-> !data_bus_oe_o)
    else $error("parallel bus driven in serial mode");
  AST_STANDBY: assert property (!standby_n_i [*6] |-> !powered_o && !busy_o)
    else $error("active during standby");
  AST_ABORT: assert property (reset_pin_i [*6] |-> !busy_o)
    else $error("conversion survives reset pin");
  AST_BYTE_LANE: assert property (s_byte_read |-> data_bus_o[7:0] == 8'h00)
    else $error("low lines used in byte mode");
  AST_SPAN: assert property (
    (!config_source_select_i && !span_clk_i && standby_n_i) [*6] |-> span_4ref_o)
    else $error("span select ignored");
  AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> |pair_start_i)
    else $error("busy without start");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : ahc_top_sva
`default_nettype wire

// file: verif/ahc_top_tb_top.sv
// Purpose: self-checking bench for ahc_top
// Assumes: host pins come from ahc_host_model
// Notes: TK shortens the conversion count
`timescale 1ns/1ns
`default_nettype none
module ahc_top_tb_top
  import ahc_pkg::*;
;
  localparam int TK = 8;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, bw, hbf, cfg, ifs, standby_n_n, span, g, ce;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dwr, wb_drd, f;
  logic [15:0] d;
  logic [NUM_CH-1:0][DATA_W-1:0] codes;
  wire logic wb_ack, oe, busy, pwr, span4, cs_n, rd_n, rpin;
  wire logic [2:0] start;
  wire logic [15:0] dbus;
  wire logic [31:0] wb_rd;
  int errors, checked, cyc_n;
  ahc_top #(.TICKS(TK)) ahc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dwr),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .parallel_select_n_i(cs_n), .read_enable_n_i(rd_n),
    .pair_start_i(start), .standby_n_i(standby_n_n), .span_clk_i(span), .reset_pin_i(rpin),
    .bus_width_select_i(bw), .high_byte_first_i(hbf), .config_source_select_i(cfg),
    .interface_select_i(ifs), .conv_code_i(codes), .data_bus_o(dbus),
    .data_bus_oe_o(oe), .busy_o(busy), .powered_o(pwr), .span_4ref_o(span4));
  ahc_host_model ahc_host_model_inst (.clk_i(clk_i), .data_i(dbus), .oe_i(oe),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .start_o(start), .reset_pin_o(rpin));
  // ----
  // shared tasks
  // ----
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 6000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = 4'hf);
    int n;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dwr, wb_sel} <= {2'b11, we, a, v, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    wb_drd = wb_rd;
    if (n >= 50) errors++;
    {wb_cyc, wb_stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 90) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(busy), 32'(v));
  endtask : wt
  task automatic tog(input int k);
    repeat (k) begin
      span <= 1'b1;
      repeat (3) @(posedge clk_i);
      span <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : tog
  // ----
  // scenarios
  // ----
  task automatic t_convert;
    int n;
    wb(1'b0, OFS_CONTROL_WORD, 32'h0);
    chk(wb_drd, CONTROL_WORD_RST);
    wb(1'b0, 8'h0c, 32'h0);
    chk(wb_drd, 32'h0);
    ahc_host_model_inst.cs(1'b0);
    ahc_host_model_inst.start(3'b111);
    wt(1'b1);
    n = 0;
    while (busy === 1'b1 && n < 99) begin
      n++;
      @(posedge clk_i);
    end
    chk(n, TK);
    chk(32'(span4), 32'h1);
    ahc_host_model_inst.start(3'b000);
    for (int c = 0; c < NUM_CH; c++) begin
      ahc_host_model_inst.rd(d, g);
      chk(32'(d), 32'(codes[c]));
    end
  endtask : t_convert
  task automatic t_bytes;
    bw <= 1'b1;
    hbf <= 1'b1;
    repeat (4) @(posedge clk_i);
    ahc_host_model_inst.rd(d, g);
    chk(32'(d), {16'h0, codes[0][15:8], 8'h00});
    ahc_host_model_inst.rd(d, g);
    chk(32'(d), {16'h0, codes[0][7:0], 8'h00});
    hbf <= 1'b0;
    repeat (4) @(posedge clk_i);
    ahc_host_model_inst.rd(d, g);
    chk(32'(d), {16'h0, codes[1][7:0], 8'h00});
    ahc_host_model_inst.rd(d, g);
    chk(32'(d), {16'h0, codes[1][15:8], 8'h00});
    bw <= 1'b0;
  endtask : t_bytes
  task automatic t_drop;
    ahc_host_model_inst.start(3'b010);
    wt(1'b1);
    ahc_host_model_inst.start(3'b000);
    wt(1'b0);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(wb_drd[ST_PD+1]), 32'h1);
  endtask : t_drop
  task automatic t_gate;
    ahc_host_model_inst.cs(1'b1);
    ahc_host_model_inst.rd(d, g);
    chk(32'(g), 32'h0);
    ifs <= 1'b1;
    wb(1'b0, OFS_FRAME_COUNT, 32'h0);
    f = wb_drd + 32'h1;
    ahc_host_model_inst.cs(1'b0);
    wb(1'b0, OFS_FRAME_COUNT, 32'h0);
    chk(wb_drd, f);
    ahc_host_model_inst.rd(d, g);
    chk(32'(g), 32'h0);
    ifs <= 1'b0;
  endtask : t_gate
  task automatic t_sw;
    cfg <= 1'b1;
    wb(1'b1, OFS_CONTROL_WORD, CONTROL_WORD_RST | (32'h1 << BIT_CLK_SRC));
    ahc_host_model_inst.start(3'b010);
    repeat (12) @(posedge clk_i);
    chk(32'(busy), 32'h0);
    codes[0] <= 16'h5a5a;
    ahc_host_model_inst.start(3'b001);
    wt(1'b1);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(wb_drd[2:0]), 32'h7);
    tog(TK + 2);
    wt(1'b0);
    ahc_host_model_inst.rd(d, g);
    chk(32'(d), 32'h5a5a);
    ahc_host_model_inst.start(3'b000);
    wb(1'b1, OFS_CONTROL_WORD, 32'h1 << BIT_SEQ_MODE, 4'h4);
    wb(1'b0, OFS_CONTROL_WORD, 32'h0);
    chk(wb_drd, CONTROL_WORD_RST | (32'h1 << BIT_CLK_SRC) | (32'h1 << BIT_SEQ_MODE));
    ahc_host_model_inst.start(3'b001);
    wt(1'b1);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(wb_drd[2:0]), 32'h1);
    repeat (20) @(posedge clk_i);
    chk(32'(busy), 32'h1);
    ahc_host_model_inst.pulse(8);
    wt(1'b0);
    wb(1'b0, OFS_CONTROL_WORD, 32'h0);
    chk(wb_drd, CONTROL_WORD_RST);
    ahc_host_model_inst.start(3'b000);
    cfg <= 1'b0;
  endtask : t_sw
  task automatic t_standby_n;
    standby_n_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'(pwr), 32'h0);
    ahc_host_model_inst.start(3'b001);
    repeat (10) @(posedge clk_i);
    chk(32'(busy), 32'h0);
    ahc_host_model_inst.start(3'b000);
    standby_n_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(pwr), 32'h1);
  endtask : t_standby_n
  task automatic t_freeze;
    ce <= 1'b0;
    span <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(span4), 32'h1);
    ce <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(span4), 32'h0);
    span <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : t_freeze
  task automatic wrap_up;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {clk_i, rst_i, wb_cyc, wb_stb, wb_we, bw, hbf, cfg, ifs, standby_n_n, span} = 11'b01000000010;
    ce = 1'b1;
    {wb_adr, wb_sel, wb_dwr, errors, checked, cyc_n} = '0;
    for (int c = 0; c < NUM_CH; c++) codes[c] = 16'h1234 + 16'(c) * 16'h1111;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_convert();
    t_bytes();
    t_drop();
    t_gate();
    t_sw();
    t_standby_n();
    t_freeze();
    wrap_up();
  end
endmodule : ahc_top_tb_top
bind ahc_top ahc_top_sva ahc_top_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .parallel_select_n_i(parallel_select_n_i), .read_enable_n_i(read_enable_n_i),
  .pair_start_i(pair_start_i), .standby_n_i(standby_n_i), .span_clk_i(span_clk_i),
  .reset_pin_i(reset_pin_i), .bus_width_select_i(bus_width_select_i),
  .config_source_select_i(config_source_select_i), .interface_select_i(interface_select_i),
  .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o), .busy_o(busy_o),
  .powered_o(powered_o), .span_4ref_o(span_4ref_o));
`default_nettype wire

// file: verilog/ahc_pair.sv
// Purpose: conversion sequencer for one channel pair
// Assumes: go_i is a one-cycle start, tick_i paces the conversion
// Notes: dropping hold_i mid conversion parks the pair in partial power-down
`timescale 1ns/1ns
`default_nettype none
module ahc_pair
  import ahc_pkg::*;
#(
  parameter int TICKS = CONV_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic abort_i,
  input wire logic go_i,
  input wire logic hold_i,
  input wire logic tick_i,
  output logic busy_o,
  output logic pd_o,
  output logic done_o
);
  typedef enum logic [1:0] {
    AHC_IDLE = 2'b01,
    AHC_CONV = 2'b10
  } ahc_pstate_t;
  ahc_pstate_t state;
  ahc_pstate_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_pd;
  logic next_done;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pd = pd_o;
    next_done = 1'b0;
    if (ce_i) begin
      unique case (state)
        AHC_IDLE: begin
          if (go_i && !abort_i) begin
            next_state = AHC_CONV;
            next_cnt = 8'(TICKS - 1);
            next_pd = 1'b0;
          end
        end
        AHC_CONV: begin
          if (abort_i) begin
            next_state = AHC_IDLE;
          end else if (!hold_i) begin
            next_state = AHC_IDLE;
            next_pd = 1'b1;
          end else if (tick_i) begin
            if (cnt == 8'h00) begin
              next_state = AHC_IDLE;
              next_done = 1'b1;
            end else begin
              next_cnt = cnt - 8'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= AHC_IDLE;
      cnt <= 8'h00;
      pd_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pd_o <= next_pd;
      done_o <= next_done;
    end
  end

  assign busy_o = (state == AHC_CONV);
endmodule : ahc_pair
`default_nettype wire

// file: verilog/ahc_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes: the first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module ahc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = meta;
    next_q = q_o;
    if (ce_i) begin
      next_meta = d_i;
      next_q = meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule : ahc_sync
`default_nettype wire

// file: verilog/ahc_top.sv
// Purpose: device-side control of a six-channel simultaneous-sampling converter
// Assumes: control pins are asynchronous; conv_code_i is on clk_i from the analog core
// Notes: control word and status are reached over classic wishbone
//
// Notes on behaviour
// - parallel interface works only while parallel_select_n is low.
// - serial mode: a falling frame_sync_n edge starts each frame transfer.
// - data_bus is driven only while read_enable_n is low.
// - hardware mode: rising pair start converts both inputs of that pair.
// - start must stay high through conversion, else pair goes to partial power-down.
// - software mode: pair B and C starts act only with sequential mode set.
// - software sequential mode: pair A start converts pair A only.
// - standby_n low clears powered, aborts every pair and disables data_bus; span select is not gated.
// - hardware mode: span pin low selects plus or minus four reference span.
// - software mode: span pin is the external conversion clock when clock bit set.
// - reset pin high aborts any conversion in progress.
// - reset loads the control word with its fixed default.
// - word mode: each result moves as one 16-bit word on all lines.
// - byte mode: two accesses on the upper byte, order set by high_byte_first.
// - busy rises at conversion start and stays high until it finishes.
// - interface_select low picks parallel, high picks serial pin roles.
`timescale 1ns/1ns
`default_nettype none
module ahc_top
  import ahc_pkg::*;
#(
  parameter int TICKS = CONV_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic parallel_select_n_i,
  input wire logic read_enable_n_i,
  input wire logic [NUM_PAIRS-1:0] pair_start_i,
  input wire logic standby_n_i,
  input wire logic span_clk_i,
  input wire logic reset_pin_i,
  input wire logic bus_width_select_i,
  input wire logic high_byte_first_i,
  input wire logic config_source_select_i,
  input wire logic interface_select_i,
  input wire logic [NUM_CH-1:0][DATA_W-1:0] conv_code_i,
  output logic [DATA_W-1:0] data_bus_o,
  output logic data_bus_oe_o,
  output logic busy_o,
  output logic powered_o,
  output logic span_4ref_o
);
  // ---------------------------------------------------------------
  // pin synchronisation and edges
  // ---------------------------------------------------------------
  ahc_pins_t pins_raw;
  ahc_pins_t pins;
  ahc_pins_t pins_q;
  ahc_pins_t next_pins_q;

  assign pins_raw = '{parallel_select_n: parallel_select_n_i,
                      read_enable_n: read_enable_n_i,
                      pair_start: pair_start_i,
                      standby_n: standby_n_i,
                      span_clk: span_clk_i,
                      reset_pin: reset_pin_i,
                      bus_width_select: bus_width_select_i,
                      high_byte_first: high_byte_first_i,
                      config_source_select: config_source_select_i,
                      interface_select: interface_select_i};

  ahc_sync #(.W(PINS_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  always_comb begin
    next_pins_q = ce_i ? pins : pins_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_q <= '0;
    end else begin
      pins_q <= next_pins_q;
    end
  end

  logic sw_cfg;
  logic serial;
  logic standby;
  logic abort;
  logic seq_mode;
  logic ext_clk;
  logic [NUM_PAIRS-1:0] start_rise;
  logic span_rise;
  logic rd_fall;
  logic rd_rise;
  logic fs_fall;
  logic [31:0] control_word;

  assign sw_cfg = pins.config_source_select;
  assign serial = pins.interface_select;
  assign standby = !pins.standby_n;
  assign abort = pins.reset_pin || standby;
  assign seq_mode = control_word[BIT_SEQ_MODE];
  assign ext_clk = sw_cfg && control_word[BIT_CLK_SRC];
  assign start_rise = pins.pair_start & ~pins_q.pair_start;
  assign span_rise = pins.span_clk && !pins_q.span_clk;
  // the shared select pin: chip select in parallel, frame sync in serial
  assign rd_fall = !serial && !pins.parallel_select_n
                   && !pins.read_enable_n && pins_q.read_enable_n;
  assign rd_rise = !serial && !pins.parallel_select_n
                   && pins.read_enable_n && !pins_q.read_enable_n;
  assign fs_fall = serial && !pins.parallel_select_n
                   && pins_q.parallel_select_n;

  // ---------------------------------------------------------------
  // conversion start steering and pair sequencers
  // ---------------------------------------------------------------
  logic [NUM_PAIRS-1:0] go;
  logic [NUM_PAIRS-1:0] hold;
  logic [NUM_PAIRS-1:0] pair_busy;
  logic [NUM_PAIRS-1:0] pair_pd;
  logic [NUM_PAIRS-1:0] pair_done;
  logic tick;

  // external clock paces conversion when selected, else every cycle
  assign tick = ext_clk ? span_rise : 1'b1;

  always_comb begin
    go = '0;
    hold = pins.pair_start;
    if (!sw_cfg) begin
      go = start_rise;
    end else if (seq_mode) begin
      go = start_rise;
    end else begin
      // pair a start launches every pair; b and c pins are tied off
      go = {NUM_PAIRS{start_rise[0]}};
      hold = {NUM_PAIRS{pins.pair_start[0]}};
    end
  end

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    ahc_pair #(.TICKS(TICKS)) u_pair (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .abort_i(abort),
      .go_i(go[p]),
      .hold_i(hold[p]),
      .tick_i(tick),
      .busy_o(pair_busy[p]),
      .pd_o(pair_pd[p]),
      .done_o(pair_done[p])
    );
  end

  // ---------------------------------------------------------------
  // results, read pointer and data bus
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] result [NUM_CH];
  logic [DATA_W-1:0] next_result [NUM_CH];
  logic [2:0] rd_ch;
  logic [2:0] next_rd_ch;
  logic rd_half;
  logic next_rd_half;
  logic [DATA_W-1:0] next_data_bus;
  logic next_data_bus_oe;
  logic [DATA_W-1:0] cur_word;
  logic [7:0] cur_byte;
  logic [15:0] frame_count;
  logic [15:0] next_frame_count;

  assign cur_word = result[rd_ch];
  assign cur_byte = (rd_half ^ pins.high_byte_first) ? cur_word[15:8]
                                                     : cur_word[7:0];

  always_comb begin
    next_result = result;
    next_rd_ch = rd_ch;
    next_rd_half = rd_half;
    next_data_bus = data_bus_o;
    next_data_bus_oe = data_bus_oe_o;
    next_frame_count = frame_count;
    if (ce_i) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        if (pair_done[p]) begin
          next_result[2*p] = conv_code_i[2*p];
          next_result[2*p+1] = conv_code_i[2*p+1];
        end
      end
      if (|go || fs_fall) begin
        next_rd_ch = 3'h0;
        next_rd_half = 1'b0;
      end else if (rd_rise) begin
        if (pins.bus_width_select && !rd_half) begin
          next_rd_half = 1'b1;
        end else begin
          next_rd_half = 1'b0;
          next_rd_ch = (rd_ch == CH_LAST) ? 3'h0 : rd_ch + 3'h1;
        end
      end
      if (fs_fall) begin
        next_frame_count = frame_count + 16'h0001;
      end
      if (rd_fall) begin
        if (pins.bus_width_select) begin
          next_data_bus = {cur_byte, 8'h00};
        end else begin
          next_data_bus = cur_word;
        end
      end
      next_data_bus_oe = !serial && !pins.parallel_select_n
                         && !pins.read_enable_n && !standby;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= '0;
      end
      rd_ch <= 3'h0;
      rd_half <= 1'b0;
      data_bus_o <= '0;
      data_bus_oe_o <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      result <= next_result;
      rd_ch <= next_rd_ch;
      rd_half <= next_rd_half;
      data_bus_o <= next_data_bus;
      data_bus_oe_o <= next_data_bus_oe;
      frame_count <= next_frame_count;
    end
  end

  // ---------------------------------------------------------------
  // status pins
  // ---------------------------------------------------------------
  logic next_busy;
  logic next_powered;
  logic next_span4;

  always_comb begin
    next_busy = busy_o;
    next_powered = powered_o;
    next_span4 = span_4ref_o;
    if (ce_i) begin
      next_busy = |pair_busy;
      next_powered = !standby;
      next_span4 = !sw_cfg && !pins.span_clk;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      powered_o <= 1'b0;
      span_4ref_o <= 1'b0;
    end else begin
      busy_o <= next_busy;
      powered_o <= next_powered;
      span_4ref_o <= next_span4;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic [31:0] status;
  logic [31:0] next_control_word;
  logic [31:0] next_wb_dat;
  logic next_wb_ack;
  logic wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    status = '0;
    status[ST_BUSY +: NUM_PAIRS] = pair_busy;
    status[ST_PD +: NUM_PAIRS] = pair_pd;
    status[ST_STANDBY] = standby;
    status[ST_SPAN4] = span_4ref_o;
    status[ST_EXT_CLK] = ext_clk;
    status[ST_SW_CFG] = sw_cfg;
    status[ST_SERIAL] = serial;
    status[ST_HALF] = rd_half;
    status[ST_CH +: 3] = rd_ch;
  end

  always_comb begin
    next_control_word = control_word;
    next_wb_dat = wb_dat_o;
    next_wb_ack = wb_ack_o;
    if (ce_i) begin
      next_wb_ack = wb_req;
      if (wb_req) begin
        unique case (wb_adr_i)
          OFS_CONTROL_WORD: next_wb_dat = control_word;
          OFS_STATUS: next_wb_dat = status;
          OFS_FRAME_COUNT: next_wb_dat = {16'h0000, frame_count};
          default: next_wb_dat = '0;
        endcase
        if (wb_we_i && wb_adr_i == OFS_CONTROL_WORD) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              next_control_word[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
          end
        end
      end
      if (pins.reset_pin) begin
        next_control_word = CONTROL_WORD_RST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_word <= CONTROL_WORD_RST;
      wb_dat_o <= '0;
      wb_ack_o <= 1'b0;
    end else begin
      control_word <= next_control_word;
      wb_dat_o <= next_wb_dat;
      wb_ack_o <= next_wb_ack;
    end
  end
endmodule : ahc_top
`default_nettype wire
